// >>> rtl/serial_shift_latch_driver.sv
`timescale 1ns/1ps
`include "sld_cfg.svh"

module serial_shift_latch_driver
    import sld_pkg::*;
#(
    parameter int STAGES = `SLD_STAGES
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              serial_clk_i,
    input  wire logic              serial_data_i,
    input  wire logic              latch_strobe_i,
    input  wire logic              blank_outputs_low_i,
    input  wire logic              force_all_high_i,
    output logic                   serial_out_o,
    output logic      [STAGES-1:0] driver_out_o
);

    pin_sample_t       pins_raw;
    pin_sample_t       sync1_reg;
    pin_sample_t       sync2_reg;
    logic              sclk_prev_reg;
    logic              strobe_prev_reg;
    pin_sample_t       sync1_next;
    pin_sample_t       sync2_next;
    logic              sclk_prev_next;
    logic              strobe_prev_next;
    pend_bit_t         pend_reg;
    pend_bit_t         pend_next;
    logic [STAGES-1:0] shift_reg;
    logic [STAGES-1:0] shift_next;
    logic [STAGES-1:0] latch_reg;
    logic [STAGES-1:0] latch_next;
    logic [STAGES-1:0] drive_reg;
    logic [STAGES-1:0] drive_next;
    logic              sclk_rise;
    logic              strobe_fall;
    logic              push_valid;
    logic              push_ready;
    logic              push_data;
    logic              pop_valid;
    logic              pop_ready;
    logic              pop_data;
    logic              pop_fire;

    ////////////////////////////////////////////////////////////////////////////////

    assign pins_raw = '{serial_clk:        serial_clk_i,
                        serial_data:       serial_data_i,
                        latch_strobe:      latch_strobe_i,
                        blank_outputs_low: blank_outputs_low_i,
                        force_all_high:    force_all_high_i};

    // Every pin crosses two flip-flops; edges are found only on the second stage.
    always_comb begin
        sync1_next       = pins_raw;
        sync2_next       = sync1_reg;
        sclk_prev_next   = sync2_reg.serial_clk;
        strobe_prev_next = sync2_reg.latch_strobe;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg       <= '0;
            sync2_reg       <= '0;
            sclk_prev_reg   <= 1'b0;
            strobe_prev_reg <= 1'b0;
        end else begin
            sync1_reg       <= sync1_next;
            sync2_reg       <= sync2_next;
            sclk_prev_reg   <= sclk_prev_next;
            strobe_prev_reg <= strobe_prev_next;
        end
    end

    assign sclk_rise   = sync2_reg.serial_clk & ~sclk_prev_reg;
    assign strobe_fall = strobe_prev_reg & ~sync2_reg.latch_strobe;

    ////////////////////////////////////////////////////////////////////////////////

    // A bit that meets a full buffer waits here; one waiting bit covers the single
    // stall cycle the drain side can cause.
    assign push_valid = pend_reg.valid | sclk_rise;
    assign push_data  = pend_reg.valid ? pend_reg.data : sync2_reg.serial_data;

    always_comb begin
        pend_next.valid = pend_reg.valid ? (~push_ready | sclk_rise) : (sclk_rise & ~push_ready);
        pend_next.data  = (pend_reg.valid & ~push_ready) ? pend_reg.data
                                                         : sync2_reg.serial_data;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    bit_fifo #(
        .WIDTH (`SLD_FIFO_WIDTH),
        .DEPTH (`SLD_FIFO_DEPTH)
    ) u_bit_fifo (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .push_valid_i (push_valid),
        .push_ready_o (push_ready),
        .push_data_i  (push_data),
        .pop_valid_o  (pop_valid),
        .pop_ready_i  (pop_ready),
        .pop_data_o   (pop_data)
    );

    // Shifting pauses in the cycle the strobe falls, so the held snapshot is settled.
    assign pop_ready = ~strobe_fall;
    assign pop_fire  = pop_valid & pop_ready;

    ////////////////////////////////////////////////////////////////////////////////

    // Blanking outranks force-high, which outranks the latch, so a test pattern never shows while the outputs are blanked.
    function automatic logic [STAGES-1:0] drive_pattern(
        input logic              blank,
        input logic              force_hi,
        input logic [STAGES-1:0] held
    );
        if (blank) begin
            drive_pattern = '0;
        end else if (force_hi) begin
            drive_pattern = `SLD_ALL_HIGH;
        end else begin
            drive_pattern = held;
        end
    endfunction

    always_comb begin
        shift_next = pop_fire ? {shift_reg[STAGES-2:0], pop_data} : shift_reg;
        latch_next = sync2_reg.latch_strobe ? shift_reg : latch_reg;
        drive_next = drive_pattern(sync2_reg.blank_outputs_low, sync2_reg.force_all_high,
                                   latch_reg);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg <= `SLD_STAGE_INIT;
            latch_reg <= `SLD_STAGE_INIT;
            drive_reg <= `SLD_STAGE_INIT;
        end else begin
            shift_reg <= shift_next;
            latch_reg <= latch_next;
            drive_reg <= drive_next;
        end
    end

    assign serial_out_o = shift_reg[STAGES-1];
    assign driver_out_o = drive_reg;

    ////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    shift_move_a: assert property (pop_fire
        |=> shift_reg[STAGES-1:1] == $past(shift_reg[STAGES-2:0]))
        else $error("Stages did not move by one place.");
    first_stage_a: assert property (pop_fire |=> shift_reg[0] == $past(pop_data))
        else $error("First stage missed the buffered data bit.");
    shift_idle_a: assert property (!pop_fire |=> $stable(shift_reg))
        else $error("Shift register changed without a clock edge.");
    edge_reach_a: assert property (sclk_rise && !pend_reg.valid |-> ##[1:3] pop_fire)
        else $error("Sampled bit did not reach the shift register in time.");
    push_fit_a: assert property (push_valid |-> push_ready)
        else $error("Buffer was full when a sampled bit arrived.");
    chain_out_a: assert property (pop_fire |=> serial_out_o == $past(shift_reg[STAGES-2]))
        else $error("Serial output is not the last stage.");
    chain_hold_a: assert property (!pop_fire |=> $stable(serial_out_o))
        else $error("Serial output changed without a shift.");
    latch_follow_a: assert property (sync2_reg.latch_strobe
        |=> latch_reg == $past(shift_reg))
        else $error("Open latch did not follow the shift register.");
    latch_hold_a: assert property (strobe_fall ##1 !sync2_reg.latch_strobe
        |-> $stable(latch_reg))
        else $error("Closed latch changed.");
    latch_closed_a: assert property (!sync2_reg.latch_strobe |=> $stable(latch_reg))
        else $error("Latch changed while the strobe was low.");
    latch_snapshot_a: assert property (strobe_fall |-> latch_reg == $past(shift_reg))
        else $error("Latch did not keep the contents from before the strobe fell.");
    blank_low_a: assert property (sync2_reg.blank_outputs_low |=> driver_out_o == '0)
        else $error("Blanking did not force the drivers low.");
    blank_wins_a: assert property (sync2_reg.blank_outputs_low && sync2_reg.force_all_high
        |=> driver_out_o == '0)
        else $error("Force-high overrode blanking.");
    force_high_a: assert property (!sync2_reg.blank_outputs_low && sync2_reg.force_all_high
        |=> driver_out_o == `SLD_ALL_HIGH)
        else $error("Force-high did not drive every output high.");
    pass_latch_a: assert property (
        !sync2_reg.blank_outputs_low && !sync2_reg.force_all_high
        |=> driver_out_o == $past(latch_reg))
        else $error("Drivers do not show the latch.");
    drive_hold_a: assert property (
        $stable(latch_reg) && $stable(sync2_reg.blank_outputs_low)
        && $stable(sync2_reg.force_all_high) |=> $stable(driver_out_o))
        else $error("Drivers changed with steady inputs.");

    shift_seen_c:   cover property (pop_fire ##1 pop_fire);
    open_shift_c:   cover property (sync2_reg.latch_strobe && pop_fire);
    strobe_seen_c:  cover property (sync2_reg.latch_strobe ##1 strobe_fall);
    blank_seen_c:   cover property (sync2_reg.blank_outputs_low ##1 !sync2_reg.blank_outputs_low);
    force_seen_c:   cover property (!sync2_reg.blank_outputs_low && sync2_reg.force_all_high);

endmodule

// >>> rtl/sld_cfg.svh
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH

// Number of shift stages, latch bits and driver outputs.
`define SLD_STAGES      48
// Depth of the bit buffer between the pin sampler and the shift register.
`define SLD_FIFO_DEPTH  4
// Width of one buffered word: a single serial data bit.
`define SLD_FIFO_WIDTH  1
// Power-up value of shift register, latch and drivers; the real part has no defined value.
`define SLD_STAGE_INIT  48'h0000_0000_0000
// Value of every driver output while the outputs are forced high.
`define SLD_ALL_HIGH    48'hFFFF_FFFF_FFFF

`endif

// >>> rtl/sld_pkg.sv
package sld_pkg;

    // Everything the display controller drives into the device, sampled together.
    typedef struct packed {
        logic serial_clk;
        logic serial_data;
        logic latch_strobe;
        logic blank_outputs_low;
        logic force_all_high;
    } pin_sample_t;

    // One bit on its way into the shift register.
    typedef struct packed {
        logic valid;
        logic data;
    } pend_bit_t;

endpackage

// >>> rtl/bit_fifo.sv
`timescale 1ns/1ps
`include "sld_cfg.svh"

module bit_fifo #(
    parameter int WIDTH = `SLD_FIFO_WIDTH,
    parameter int DEPTH = `SLD_FIFO_DEPTH
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             push_valid_i,
    output logic                  push_ready_o,
    input  wire logic [WIDTH-1:0] push_data_i,
    output logic                  pop_valid_o,
    input  wire logic             pop_ready_i,
    output logic      [WIDTH-1:0] pop_data_o
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    rd_ptr_next;
    logic [PW:0]      count_reg;
    logic [PW:0]      count_next;
    logic             push_fire;
    logic             pop_fire;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign push_ready_o = (count_reg != (PW+1)'(DEPTH));
    assign pop_valid_o  = (count_reg != '0);
    assign pop_data_o   = mem_reg[rd_ptr_reg];
    assign push_fire    = push_valid_i & push_ready_o;
    assign pop_fire     = pop_valid_o & pop_ready_i;

    always_comb begin
        wr_ptr_next = push_fire ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
        rd_ptr_next = pop_fire ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
        count_next  = count_reg + (PW+1)'(push_fire) - (PW+1)'(pop_fire);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // Storage needs no reset; only the count decides what is valid.
    always_ff @(posedge sys_clk_i) begin
        if (push_fire) begin
            mem_reg[wr_ptr_reg] <= push_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    fifo_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        count_reg <= (PW+1)'(DEPTH))
        else $error("Buffer count above its depth.");

endmodule

// >>> test/disp_ctrl_model.sv
`timescale 1ns/1ps

// Display controller: one bit per 20 cycles or more, inside the 0.5 MHz serial clock limit.
module disp_ctrl_model (
    input  wire logic sys_clk_i,
    output logic      serial_clk_o,
    output logic      serial_data_o,
    output logic      latch_strobe_o,
    output logic      blank_outputs_low_o,
    output logic      force_all_high_o
);

    initial begin
        serial_clk_o        = 1'b0;
        serial_data_o       = 1'b0;
        latch_strobe_o      = 1'b0;
        blank_outputs_low_o = 1'b0;
        force_all_high_o    = 1'b0;
    end

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // The data pin has no pull, so after the hold time it shows the inverse bit.
    task automatic send_bit(input logic b);
        serial_data_o <= b;
        wait_cycles(5);
        serial_clk_o <= 1'b1;
        wait_cycles(4);
        serial_data_o <= ~b;
        wait_cycles(1);
        serial_clk_o <= 1'b0;
        wait_cycles(10);
    endtask

    task automatic set_ctl(input logic s, input logic b, input logic f);
        latch_strobe_o      <= s;
        blank_outputs_low_o <= b;
        force_all_high_o    <= f;
    endtask

endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
`include "sld_cfg.svh"

module tb_top;

    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        serial_clk;
    logic        serial_data;
    logic        latch_strobe;
    logic        blank_outputs_low;
    logic        force_all_high;
    logic        serial_out;
    logic [47:0] driver_out;
    logic [47:0] model_sr = '0;
    logic [47:0] model_latch = '0;
    int          err_count = 0;
    int          compares = 0;

    always #50 sys_clk = ~sys_clk;

    serial_shift_latch_driver #(.STAGES(`SLD_STAGES)) serial_shift_latch_driver_inst (
        .sys_clk_i           (sys_clk),
        .rst_n_i             (rst_n),
        .serial_clk_i        (serial_clk),
        .serial_data_i       (serial_data),
        .latch_strobe_i      (latch_strobe),
        .blank_outputs_low_i (blank_outputs_low),
        .force_all_high_i    (force_all_high),
        .serial_out_o        (serial_out),
        .driver_out_o        (driver_out)
    );

    disp_ctrl_model disp_ctrl_model_inst (
        .sys_clk_i           (sys_clk),
        .serial_clk_o        (serial_clk),
        .serial_data_o       (serial_data),
        .latch_strobe_o      (latch_strobe),
        .blank_outputs_low_o (blank_outputs_low),
        .force_all_high_o    (force_all_high)
    );

    ////////////////////////////////////////////////////////////////////////////////

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic waitc(input int n);
        disp_ctrl_model_inst.wait_cycles(n);
    endtask

    // Shifts w[n-1] first; the check waits out the synchroniser before the next rise.
    task automatic shift_bits(input logic [47:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            disp_ctrl_model_inst.send_bit(w[i]);
            model_sr = {model_sr[46:0], w[i]};
            waitc(3);
            check("serial_out", {47'h0, serial_out}, {47'h0, model_sr[47]});
            if (latch_strobe) begin
                model_latch = model_sr;
                check("driver_transparent", driver_out, model_sr);
            end
        end
    endtask

    task automatic latch_pulse();
        waitc(8);
        disp_ctrl_model_inst.set_ctl(1'b1, 1'b0, 1'b0);
        waitc(5);
        disp_ctrl_model_inst.set_ctl(1'b0, 1'b0, 1'b0);
        model_latch = model_sr;
        waitc(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    task automatic t_load();
        check("driver_reset", driver_out, 48'h0000_0000_0000);
        shift_bits(48'hA5C3_0F96_1E87, 48);
        check("driver_before_strobe", driver_out, 48'h0000_0000_0000);
        latch_pulse();
        check("driver_loaded", driver_out, 48'hA5C3_0F96_1E87);
        shift_bits(48'h0123_4567_89AB, 48);
        check("driver_held", driver_out, 48'hA5C3_0F96_1E87);
    endtask

    task automatic t_transparent();
        disp_ctrl_model_inst.set_ctl(1'b1, 1'b0, 1'b0);
        waitc(6);
        shift_bits(48'hFFFF_0000_F0F0, 48);
        disp_ctrl_model_inst.set_ctl(1'b0, 1'b0, 1'b0);
        waitc(6);
        shift_bits(48'h0000_0000_0005, 4);
        check("driver_after_fall", driver_out, model_latch);
    endtask

    // Blank is held 100 cycles and force 200; 100 cycles is the minimum pulse width of those pins.
    task automatic t_override();
        disp_ctrl_model_inst.set_ctl(1'b1, 1'b1, 1'b1);
        waitc(10);
        disp_ctrl_model_inst.set_ctl(1'b0, 1'b1, 1'b1);
        model_latch = model_sr;
        waitc(90);
        check("driver_blank", driver_out, 48'h0000_0000_0000);
        disp_ctrl_model_inst.set_ctl(1'b0, 1'b0, 1'b1);
        waitc(100);
        check("driver_force", driver_out, 48'hFFFF_FFFF_FFFF);
        disp_ctrl_model_inst.set_ctl(1'b0, 1'b0, 1'b0);
        waitc(100);
        check("driver_release", driver_out, model_latch);
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        waitc(2);
        t_load();
        t_transparent();
        t_override();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        end_of_test();
    end

endmodule
